/* File: spp_top.v */
// Serial peripheral port: AHB-Lite register slave, master/slave byte shifter and pin drivers.
//
// Contract
// RULE1 - Enable bit switches port on at 1, off at 0; reset clears it.
// RULE2 - Open-drain bit set disables high drive on all port outputs together.
// RULE3 - Role bit 1 selects master, 0 slave; reset gives slave.
// RULE4 - Idle master clock sits at the polarity bit level.
// RULE5 - Phase 0: select falling starts transaction; first clock edge samples data.
// RULE6 - Phase 1: select acts only as slave output enable, no restart.
// RULE7 - Master rate bits divide clock by 2, 4, 16, 32; slave ignores them.
// RULE8 - Byte end sets done flag; interrupt when done set and enabled.
// RULE9 - Done flag clears by status read seeing it, then data access.
// RULE10 - After first transfer, data writes ignored until status read sees done.
// RULE11 - Data write during a transfer sets the write collision flag.
// RULE12 - Collision window: phase 0 select low span; phase 1 first clock to done.
// RULE13 - Collision flag clears by status read seeing it, then data access.
// RULE14 - Fault flag sets when master sees select low; interrupts if enabled.
// RULE15 - Fault setting clears enable and role bits.
// RULE16 - Fault flag clears by status read seeing it, then control write.
// RULE17 - Status bits 5 and 3 to 0 read as zero.
// RULE18 - Only a data write starts a transfer, and only as master.
// RULE19 - Done flag sets at byte end in master and slave alike.
// RULE20 - Reads return receive buffer; byte arriving before done cleared is dropped.
// RULE21 - Data write loads the shift register directly, no transmit buffer.
// RULE22 - Data shifts most significant bit first on both lines.
// RULE23 - Master gives exactly eight clock pulses, then returns clock to idle.
// RULE24 - Unselected slave leaves its master-in line undriven.
// RULE25 - External master holds select low per transaction; phase 0 raises it between bytes.
`timescale 1ns/1ps
`default_nettype none
`include "spp_defines.vh"

module spp_top (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    // Serial clock pin
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe,
    // Master-out slave-in pin
    input  wire        mosi_in,
    output reg         mosi_out,
    output reg         mosi_oe,
    // Master-in slave-out pin
    input  wire        miso_in,
    output reg         miso_out,
    output reg         miso_oe,
    // Slave select input, active low
    input  wire        slave_select_n_in,
    // Interrupt request
    output reg         serial_irq
);

    // ============================================================
    // Pin synchronisers
    wire [3:0] pins_sync;
    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;
    wire       ss_n_s;

    spp_sync u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({slave_select_n_in, miso_in, mosi_in, sck_in}),
        .sync_out (pins_sync)
    );

    assign sck_s  = pins_sync[0];
    assign mosi_s = pins_sync[1];
    assign miso_s = pins_sync[2];
    assign ss_n_s = pins_sync[3];

    // ============================================================
    // Control, status and data state
    reg        irq_enable;
    reg        port_enable;
    reg        open_drain_select;
    reg        role_select;
    reg        clock_polarity;
    reg        clock_phase;
    reg [1:0]  rate_select;
    reg        transfer_done_flag;
    reg        write_collision_flag;
    reg        role_fault_flag;
    reg        done_armed;
    reg        write_collision_flag_armed;
    reg        fault_armed;
    reg        write_lock;
    reg [7:0]  receive_buffer;

    // Shift engine state
    reg [7:0]  shift_reg;
    reg        out_bit;
    reg        sample_bit;
    reg [2:0]  bit_count;
    reg        master_busy;
    reg        slave_active;
    reg        slave_hold;
    reg [3:0]  half_count;
    reg        sck_phase;
    reg        sck_level_prev;
    reg        ss_n_prev;

    // Bus data phase
    reg        acc_pend;
    reg        acc_write;
    reg [29:0] acc_idx;

    // ============================================================
    // Bus decode
    wire addr_ok = hsel & hready & htrans[1] & (hsize == `SPP_HSIZE_WORD) &
                   (haddr[1:0] == 2'h0);
    wire wr_ctrl  = acc_pend & acc_write & (acc_idx == `SPP_IDX_CTRL);
    wire rd_stat  = acc_pend & ~acc_write & (acc_idx == `SPP_IDX_STAT);
    wire acc_data = acc_pend & (acc_idx == `SPP_IDX_DATA);
    wire wr_data  = acc_data & acc_write;

    wire [7:0] ctrl_val = {irq_enable, port_enable, open_drain_select, role_select,
                           clock_polarity, clock_phase, rate_select};
    wire [7:0] stat_val = {transfer_done_flag, write_collision_flag, 1'b0,
                           role_fault_flag, 4'h0}; // [RULE17]
    reg  [7:0] rd_val;

    always @* begin
        rd_val = 8'h00;
        if (acc_idx == `SPP_IDX_CTRL) begin
            rd_val = ctrl_val;
        end else if (acc_idx == `SPP_IDX_STAT) begin
            rd_val = stat_val;
        end else if (acc_idx == `SPP_IDX_DATA) begin
            rd_val = receive_buffer; // [RULE20]
        end
    end

    // ============================================================
    // AHB-Lite slave: one wait state so read data comes from a flop.
    always @(posedge core_clk) begin
        if (reset) begin
            acc_pend  <= 1'b0;
            acc_write <= 1'b0;
            acc_idx   <= 30'h00000000;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            hresp     <= 1'b0;
        end else begin
            if (acc_pend) begin
                acc_pend  <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= acc_write ? 32'h00000000 : {24'h000000, rd_val};
            end else if (addr_ok) begin
                acc_pend  <= 1'b1;
                hreadyout <= 1'b0;
                acc_write <= hwrite;
                acc_idx   <= haddr[31:2];
            end
        end
    end

    // ============================================================
    // Edge events of the shift clock
    reg [3:0] half_limit;

    always @* begin
        case (rate_select) // [RULE7]
            2'h0:    half_limit = `SPP_HALF_DIV2;
            2'h1:    half_limit = `SPP_HALF_DIV4;
            2'h2:    half_limit = `SPP_HALF_DIV16;
            default: half_limit = `SPP_HALF_DIV32;
        endcase
    end

    wire is_master  = port_enable & role_select;
    wire is_slave   = port_enable & ~role_select;
    wire m_tick     = master_busy & (half_count == half_limit);
    wire sck_level  = sck_s ^ clock_polarity;
    wire selected   = ~ss_n_s;
    wire ss_fall    = ss_n_prev & ~ss_n_s;
    wire ss_rise    = ~ss_n_prev & ss_n_s;
    // Phase 0 only counts edges inside a select window that has not finished its byte.
    wire s_window   = is_slave & selected & (clock_phase | (slave_active & ~slave_hold));
    wire s_lead     = s_window & sck_level & ~sck_level_prev;
    wire s_trail    = s_window & ~sck_level & sck_level_prev;
    wire lead       = (m_tick & ~sck_phase) | s_lead;
    wire trail      = (m_tick & sck_phase) | s_trail;
    wire data_in    = role_select ? miso_s : mosi_s;
    wire done       = trail & (bit_count == 3'h7);
    wire [7:0] shift_next = {shift_reg[6:0], clock_phase ? data_in : sample_bit}; // [RULE22]
    wire busy       = master_busy | slave_active & (clock_phase | ~slave_hold) |
                      slave_active & ~clock_phase; // [RULE12]
    wire fault_hit  = is_master & ~ss_n_s; // [RULE14]
    wire done_clear = acc_data & done_armed; // [RULE9]

    // ============================================================
    // Registers, flags and shift engine
    always @(posedge core_clk) begin
        if (reset) begin
            {irq_enable, port_enable, open_drain_select, role_select,
             clock_polarity, clock_phase, rate_select} <= `SPP_CTRL_RESET; // [RULE1] [RULE3]
            transfer_done_flag   <= 1'b0;
            write_collision_flag <= 1'b0;
            role_fault_flag      <= 1'b0;
            done_armed           <= 1'b0;
            write_collision_flag_armed           <= 1'b0;
            fault_armed          <= 1'b0;
            write_lock           <= 1'b0;
            receive_buffer       <= 8'h00;
            shift_reg            <= 8'h00;
            out_bit              <= 1'b0;
            sample_bit           <= 1'b0;
            bit_count            <= 3'h0;
            master_busy          <= 1'b0;
            slave_active         <= 1'b0;
            slave_hold           <= 1'b0;
            half_count           <= 4'h0;
            sck_phase            <= 1'b0;
            sck_level_prev       <= 1'b0;
            ss_n_prev            <= 1'b1;
        end else begin
            sck_level_prev <= sck_level;
            ss_n_prev      <= ss_n_s;

            // Status reads arm the clearing sequences.
            if (rd_stat & transfer_done_flag) begin
                done_armed <= 1'b1;
                write_lock <= 1'b0; // [RULE10]
            end
            if (rd_stat & write_collision_flag) begin
                write_collision_flag_armed <= 1'b1;
            end
            if (rd_stat & role_fault_flag) begin
                fault_armed <= 1'b1;
            end

            // Clearing accesses; any later set in this cycle overrides them.
            if (acc_data) begin
                done_armed <= 1'b0;
                write_collision_flag_armed <= 1'b0;
                if (done_armed) begin
                    transfer_done_flag <= 1'b0; // [RULE9]
                end
                if (write_collision_flag_armed) begin
                    write_collision_flag <= 1'b0; // [RULE13]
                end
            end

            if (wr_ctrl) begin
                irq_enable        <= hwdata[`SPP_CTRL_IRQ_EN];
                port_enable       <= hwdata[`SPP_CTRL_PORT_EN]; // [RULE1]
                open_drain_select <= hwdata[`SPP_CTRL_OD_SEL];
                role_select       <= hwdata[`SPP_CTRL_ROLE]; // [RULE3]
                clock_polarity    <= hwdata[`SPP_CTRL_CLOCK_POLARITY];
                clock_phase       <= hwdata[`SPP_CTRL_CLOCK_PHASE];
                rate_select       <= {hwdata[`SPP_CTRL_RATE_HI], hwdata[`SPP_CTRL_RATE_LO]};
                fault_armed       <= 1'b0;
                if (fault_armed) begin
                    role_fault_flag <= 1'b0; // [RULE16]
                end
            end

            // Data register writes.
            if (wr_data) begin
                if (busy) begin
                    write_collision_flag <= 1'b1; // [RULE11]
                end else if (!write_lock) begin
                    shift_reg <= hwdata[7:0]; // [RULE21]
                    if (!clock_phase) begin
                        out_bit <= hwdata[7];
                    end
                    bit_count <= 3'h0;
                    if (is_master) begin
                        master_busy <= 1'b1; // [RULE18]
                        half_count  <= 4'h0;
                        sck_phase   <= 1'b0;
                    end
                end
            end

            // Master clock generator.
            if (master_busy) begin
                if (m_tick) begin
                    half_count <= 4'h0;
                    sck_phase  <= ~sck_phase;
                end else begin
                    half_count <= half_count + 4'h1;
                end
            end

            // Slave select framing.
            if (is_slave) begin
                if (!clock_phase && ss_fall) begin
                    slave_active <= 1'b1; // [RULE5] [RULE12]
                    slave_hold   <= 1'b0;
                    bit_count    <= 3'h0;
                    out_bit      <= shift_reg[7];
                end else if (!clock_phase && ss_rise) begin
                    slave_active <= 1'b0;
                    slave_hold   <= 1'b0;
                end
                if (clock_phase && s_lead) begin
                    slave_active <= 1'b1; // [RULE6] [RULE12]
                end
            end

            // Shift edges: phase 0 samples on the leading edge, phase 1 on the trailing.
            if (lead) begin
                if (clock_phase) begin
                    out_bit <= shift_reg[7];
                end else begin
                    sample_bit <= data_in; // [RULE5]
                end
            end
            if (trail) begin
                shift_reg <= shift_next;
                bit_count <= bit_count + 3'h1;
                if (!clock_phase) begin
                    out_bit <= shift_reg[6];
                end
            end
            if (done) begin
                write_lock  <= 1'b1; // [RULE10]
                master_busy <= 1'b0; // [RULE23]
                sck_phase   <= 1'b0;
                if (clock_phase) begin
                    slave_active <= 1'b0;
                end else begin
                    slave_hold <= 1'b1;
                end
                transfer_done_flag <= 1'b1; // [RULE8] [RULE19]
                // A byte finishing while the old flag still stands is lost.
                if (!transfer_done_flag || done_clear) begin
                    receive_buffer <= shift_next; // [RULE20]
                end
            end

            // Mode fault drops the port back to disabled slave.
            if (fault_hit) begin
                role_fault_flag <= 1'b1; // [RULE14]
                port_enable     <= 1'b0; // [RULE15]
                role_select     <= 1'b0; // [RULE15]
            end

            // A disabled port abandons any partial byte.
            if (!port_enable || fault_hit) begin
                master_busy  <= 1'b0;
                slave_active <= 1'b0;
                slave_hold   <= 1'b0;
                sck_phase    <= 1'b0;
                half_count   <= 4'h0;
            end
        end
    end

    // ============================================================
    // Pin drivers, registered so every output leaves a flop.
    // Open-drain mode only enables the driver while pulling low.
    wire sck_val  = clock_polarity ^ sck_phase; // [RULE4] [RULE23]
    wire m_drive  = is_master;
    wire s_drive  = is_slave & selected; // [RULE24] [RULE6]

    always @(posedge core_clk) begin
        if (reset) begin
            sck_out    <= 1'b0;
            sck_oe     <= 1'b0;
            mosi_out   <= 1'b0;
            mosi_oe    <= 1'b0;
            miso_out   <= 1'b0;
            miso_oe    <= 1'b0;
            serial_irq <= 1'b0;
        end else begin
            sck_out    <= sck_val;
            sck_oe     <= m_drive & (~open_drain_select | ~sck_val); // [RULE2]
            mosi_out   <= out_bit;
            mosi_oe    <= m_drive & (~open_drain_select | ~out_bit); // [RULE2]
            miso_out   <= out_bit;
            miso_oe    <= s_drive & (~open_drain_select | ~out_bit); // [RULE2] [RULE24]
            serial_irq <= irq_enable & (transfer_done_flag | role_fault_flag); // [RULE8] [RULE14]
        end
    end

endmodule

`default_nettype wire

/* File: spp_defines.vh */
// Register map, field positions, reset values and rate counts of the serial peripheral port.
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH

// ============================================================
// Register indices; the byte address is four times the index.
`define SPP_IDX_CTRL      30'h0000000A
`define SPP_IDX_STAT      30'h0000000B
`define SPP_IDX_DATA      30'h0000000C

// ============================================================
// Control register fields.
`define SPP_CTRL_IRQ_EN   7
`define SPP_CTRL_PORT_EN  6
`define SPP_CTRL_OD_SEL   5
`define SPP_CTRL_ROLE     4
`define SPP_CTRL_CLOCK_POLARITY     3
`define SPP_CTRL_CLOCK_PHASE     2
`define SPP_CTRL_RATE_HI  1
`define SPP_CTRL_RATE_LO  0
`define SPP_CTRL_RESET    8'h04

// ============================================================
// Status register fields; every other bit reads as zero.
`define SPP_STAT_DONE     7
`define SPP_STAT_WRITE_COLLISION_FLAG     6
`define SPP_STAT_FAULT    4

// ============================================================
// Half period of the master clock, in core clock cycles minus one.
`define SPP_HALF_DIV2     4'h0
`define SPP_HALF_DIV4     4'h1
`define SPP_HALF_DIV16    4'h7
`define SPP_HALF_DIV32    4'hF

// ============================================================
// Bus encodings.
`define SPP_HSIZE_WORD    3'h2
`define SPP_SYNC_WIDTH    4

`endif

/* File: spp_sync.v */
// Two-flop synchronisers for the serial pin inputs.
`timescale 1ns/1ps
`default_nettype none

module spp_sync (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Asynchronous inputs and their synchronised copies
    input  wire [3:0] async_in,
    output wire [3:0] sync_out
);

    reg [3:0] stage1;
    reg [3:0] stage2;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_bit
            // Idle level high so that a released select reads as unselected.
            always @(posedge core_clk) begin
                if (reset) begin
                    stage1[i] <= 1'b1;
                    stage2[i] <= 1'b1;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2;

endmodule

`default_nettype wire

/* File: spp_top_properties.sv */
// Concurrent checks on the bus and pin behaviour of the serial peripheral port.
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Checker
module spp_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Pins
    input wire logic        sck_oe,
    input wire logic        mosi_oe,
    input wire logic        miso_oe,
    input wire logic        slave_select_n_in,
    input wire logic        serial_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic taken;
    assign taken = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[1:0] == 2'h0;

    a_bus_okay: assert property (!hresp)
        else $error("bus answered with an error");
    a_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
        else $error("data phase did not take exactly one wait cycle");
    a_write_reads_zero: assert property (taken && hwrite |-> ##2 hrdata == 32'h0)
        else $error("read data not zero after a write");
    a_status_unused: assert property (
        taken && !hwrite && haddr == 32'h0000002C |-> ##2 hrdata[5] == 1'b0 && hrdata[3:0] == 4'h0)
        else $error("unused status bits read as one");
    a_reset_quiet: assert property (
        $fell(reset) |-> hreadyout && !serial_irq && !sck_oe && !mosi_oe && !miso_oe)
        else $error("outputs active straight after reset");
    a_miso_release: assert property (slave_select_n_in [*5] |-> !miso_oe)
        else $error("unselected slave still drives its data line");
    a_miso_master: assert property ((sck_oe || mosi_oe) |-> !miso_oe)
        else $error("master drives the slave data line");
    a_fault_release: assert property (sck_oe && !slave_select_n_in |-> ##[1:6] !sck_oe)
        else $error("master kept driving after its select went low");
endmodule

bind spp_top spp_checker u_chk (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
    .slave_select_n_in(slave_select_n_in), .serial_irq(serial_irq)
);

`default_nettype wire

/* File: spp_peer_model.sv */
// Behavioural far-side serial device using clock polarity 0 and phase 1.
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Peer device
module spp_peer_model (
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       select_n,
    output var  logic       miso,
    // Byte exchange
    input  wire logic [7:0] tx_byte,
    output var  logic [7:0] rx_byte
);
    logic [2:0] bit_idx;

    initial begin
        miso = 1'b0;
        rx_byte = 8'h00;
        bit_idx = 3'h0;
    end
    always @(negedge select_n) begin
        bit_idx <= 3'h0;
    end
    // Nothing pulls the line, so a released output flips to show it carries no data.
    always @(posedge select_n) begin
        miso <= ~miso;
    end
    always @(posedge sck) begin
        if (!select_n) begin
            miso <= tx_byte[3'h7 - bit_idx];
        end
    end
    always @(negedge sck) begin
        if (!select_n) begin
            rx_byte <= {rx_byte[6:0], mosi};
            bit_idx <= bit_idx + 3'h1;
        end
    end
endmodule

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the serial peripheral port.
`timescale 1ns/1ps
`default_nettype none
`include "spp_defines.vh"

// ========================================
// Bench
module tb;
    localparam logic [31:0] A_CTRL = {`SPP_IDX_CTRL, 2'h0};
    localparam logic [31:0] A_STAT = {`SPP_IDX_STAT, 2'h0};
    localparam logic [31:0] A_DATA = {`SPP_IDX_DATA, 2'h0};
    localparam int          HALF[4] = '{1, 2, 8, 16};
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        tb_sck = 1'b0;
    logic        tb_mosi = 1'b0;
    logic        ss_n = 1'b1;
    logic        peer_ss_n = 1'b1;
    logic [7:0]  peer_tx = 8'h00;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    wire         hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe;
    wire         miso_out, miso_oe, serial_irq, peer_miso;
    wire  [31:0] hrdata;
    wire  [7:0]  peer_rx;
    wire         sck_pin = sck_oe ? sck_out : tb_sck;
    wire         mosi_pin = mosi_oe ? mosi_out : tb_mosi;
    wire         miso_pin = miso_oe ? miso_out : peer_miso;

    always #10 core_clk = ~core_clk;

    spp_top dut (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(`SPP_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sck_in(sck_pin),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe),
        .slave_select_n_in(ss_n), .serial_irq(serial_irq)
    );
    spp_peer_model peer (
        .sck(sck_pin), .mosi(mosi_pin), .select_n(peer_ss_n), .miso(peer_miso),
        .tx_byte(peer_tx), .rx_byte(peer_rx)
    );

    task automatic tally_and_finish();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, {24'h0, d}, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, {24'h0, exp});
    endtask

    task automatic t_reset();
        rd(A_CTRL, `SPP_CTRL_RESET);
        rd(A_STAT, 8'h00);
        rd(32'h00000040, 8'h00);
    endtask

    // Bench-driven external master; half period of six cycles clears the input synchronisers.
    task automatic t_slave();
        logic [7:0] got;
        logic [7:0] tx;
        wr(A_CTRL, 8'h44);
        wr(A_DATA, 8'h3C);
        ss_n <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            tx = k == 0 ? 8'hC3 : 8'h99;
            got = 8'h00;
            for (int i = 7; i >= 0; i--) begin
                repeat (6) @(posedge core_clk);
                tb_sck <= 1'b1;
                tb_mosi <= tx[i];
                repeat (6) @(posedge core_clk);
                tb_sck <= 1'b0;
                got = {got[6:0], miso_out};
            end
            repeat (8) @(posedge core_clk);
            chk(got, k == 0 ? 8'h3C : 8'hC3);
            rd(A_STAT, 8'h80);
        end
        rd(A_DATA, 8'hC3);
        rd(A_STAT, 8'h00);
        ss_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic t_master();
        wr(A_CTRL, 8'hD7);
        peer_tx <= 8'h5A;
        peer_ss_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(sck_out, 1'b0);
        wr(A_DATA, 8'hA5);
        repeat (300) @(posedge core_clk);
        wr(A_DATA, 8'h11);
        chk(serial_irq, 1'b1);
        rd(A_STAT, 8'h80);
        chk(peer_rx, 8'hA5);
        rd(A_DATA, 8'h5A);
        rd(A_STAT, 8'h00);
        repeat (300) @(posedge core_clk);
        chk(serial_irq, 1'b0);
        rd(A_STAT, 8'h00);
    endtask

    task automatic t_collision();
        wr(A_DATA, 8'h0F);
        repeat (20) @(posedge core_clk);
        wr(A_DATA, 8'hF0);
        repeat (300) @(posedge core_clk);
        rd(A_STAT, 8'hC0);
        chk(peer_rx, 8'h0F);
        rd(A_DATA, 8'h5A);
        rd(A_STAT, 8'h00);
        peer_ss_n <= 1'b1;
    endtask

    task automatic t_rates();
        int   first;
        int   last;
        int   toggles;
        logic prev;
        logic [31:0] junk;
        for (int r = 0; r < 4; r++) begin
            wr(A_CTRL, {4'h5, r[0], r[1], r[1:0]});
            repeat (2) @(posedge core_clk);
            chk(sck_out, r[0]);
            wr(A_DATA, 8'h96);
            toggles = 0;
            first = 0;
            last = 0;
            prev = sck_out;
            for (int n = 0; n < 600; n++) begin
                @(posedge core_clk);
                if (sck_out !== prev) begin
                    if (toggles == 0) first = n;
                    last = n;
                    toggles++;
                end
                prev = sck_out;
            end
            chk(toggles, 16);
            chk(last - first, 15 * HALF[r]);
            chk(sck_out, r[0]);
            rd(A_STAT, 8'h80);
            bus(1'b0, A_DATA, 32'h0, junk);
        end
    endtask

    task automatic t_fault();
        wr(A_CTRL, 8'h7C);
        repeat (3) @(posedge core_clk);
        chk(sck_oe, 1'b0);
        wr(A_CTRL, 8'hDC);
        repeat (3) @(posedge core_clk);
        chk(sck_oe, 1'b1);
        ss_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(serial_irq, 1'b1);
        rd(A_STAT, 8'h10);
        rd(A_CTRL, 8'h8C);
        ss_n <= 1'b1;
        wr(A_CTRL, 8'h00);
        rd(A_STAT, 8'h00);
    endtask

    // The longest run is about 3700 cycles; the limit leaves ample margin.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_slave();
        t_master();
        t_collision();
        t_rates();
        t_fault();
        tally_and_finish();
    end
endmodule

`default_nettype wire
